// [rtl/uefc_pkg.sv]
// Package of offsets, field positions and reset values of the feature block.
// Summary of operation
// - Sub-mode 0: only already pending flow character leaves.
// - Sub-mode 1: flow characters still sent, data held.
// - Receive sub-mode 0: ignore data and flow characters.
// - Receive sub-mode 1: drop data, still act on flow.
// - Scratch byte, read/write, resets to all ones.
// - Table select; tables A-C use next trigger level.
// - RS-485 direction overrides automatic RTS/DTR control.
// - Direction low after last stop, high on load.
// - Transmit interrupt source: shift or holding empty.
// - Direction unchanged for flow character with empty FIFO.
// - IrDA receive polarity bit inverts encoded input.
// - Hysteresis field used only for table D.
// - Hysteresis code to character count mapping.
// - Four-bit single or dual flow character select.
// - Auto CTS/DSR stops transmit while input high.
// - Auto RTS/DTR follows receive level thresholds.
// - Output general purpose unless hardware flow or RS-485 active.
// - Special character match stores byte, flags status.
// - Second-pair compare: match not stored, two interrupts.
// - Enhanced bits writable only while enable set.
// - Reset clears enable and gated enhanced bits.
// - Transmitter disable halts all transmit data.
// - Receiver disable finishes current character, then stops.
package uefc_pkg;
   // Register offsets of this block, in a small local space.
   localparam logic [3:0] UEFC_OFF_SCRATCH  = 4'h0;
   localparam logic [3:0] UEFC_OFF_FEATURE  = 4'h1;
   localparam logic [3:0] UEFC_OFF_ENHANCED = 4'h2;
   localparam logic [3:0] UEFC_OFF_MODEM_AUX = 4'h3;
   localparam logic [3:0] UEFC_OFF_MODEM_CTL = 4'h4;
   localparam logic [3:0] UEFC_OFF_IRQ_EN   = 4'h5;
   localparam logic [3:0] UEFC_OFF_FIFO_CTL = 4'h6;
   localparam logic [3:0] UEFC_OFF_FLOW_CHR = 4'h7;
   localparam logic [3:0] UEFC_OFF_STATUS   = 4'h8;
   // Reset values.
   localparam logic [7:0] UEFC_RST_SCRATCH  = 8'hFF;
   localparam logic [7:0] UEFC_RST_ZERO     = 8'h00;
   // Feature control field positions.
   localparam int UEFC_FC_TABLE_HI = 7;
   localparam int UEFC_FC_TABLE_LO = 6;
   localparam int UEFC_FC_RS485    = 5;
   localparam int UEFC_FC_IRPOL    = 4;
   // Enhanced feature field positions.
   localparam int UEFC_EF_AUTO_CTS = 7;
   localparam int UEFC_EF_AUTO_RTS = 6;
   localparam int UEFC_EF_SPECIAL  = 5;
   localparam int UEFC_EF_ENH_EN   = 4;
   // Modem auxiliary write-only bits.
   localparam int UEFC_MA_TX_DIS   = 3;
   localparam int UEFC_MA_RX_DIS   = 2;
   localparam int UEFC_MA_TX_MODE  = 1;
   localparam int UEFC_MA_RX_MODE  = 0;
   // Modem control select bit (DTR/DSR when set).
   localparam int UEFC_MC_SEL      = 2;
   // Masks of gated enhanced bits.
   localparam logic [7:0] UEFC_MASK_753 = 8'hE0;
   localparam logic [7:0] UEFC_MASK_54  = 8'h30;
   localparam logic [7:0] UEFC_MASK_ALL = 8'hFF;
   // Table D select code.
   localparam logic [1:0] UEFC_TABLE_D  = 2'h3;
endpackage

// [rtl/uefc_gated_reg.sv]
// One byte register whose enhanced bits are write-protected by a gate.
`timescale 1ns/1ps
module uefc_gated_reg
   import uefc_pkg::*;
#(
   parameter logic [7:0] GATED = 8'hFF
) (
   // Clock and reset.
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   // Write side.
   input  wire logic       wr,
   input  wire logic       gate_open,
   input  wire logic [7:0] wdata,
   // Stored value.
   output logic      [7:0] q
);
   // Legacy bits always write, gated bits only while the gate is open.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= UEFC_RST_ZERO;
      end else if (wr) begin
         q <= (wdata & ~GATED) | ((gate_open ? wdata : q) & GATED);
      end
   end
endmodule

// [rtl/uefc_hyst_lut.sv]
// Table of hysteresis code to character count.
`timescale 1ns/1ps
module uefc_hyst_lut (
   // Code in.
   input  wire logic [3:0] code,
   // Characters out.
   output logic      [5:0] chars
);
   // Codes 8 to 11 lie above 12 to 15, as the table is ordered.
   always_comb begin
      case (code)
         4'h0: chars = 6'h00;
         4'h1: chars = 6'h04;
         4'h2: chars = 6'h06;
         4'h3: chars = 6'h08;
         4'h4: chars = 6'h08;
         4'h5: chars = 6'h10;
         4'h6: chars = 6'h18;
         4'h7: chars = 6'h20;
         4'h8: chars = 6'h28;
         4'h9: chars = 6'h2C;
         4'hA: chars = 6'h30;
         4'hB: chars = 6'h34;
         4'hC: chars = 6'h0C;
         4'hD: chars = 6'h14;
         4'hE: chars = 6'h1C;
         default: chars = 6'h24;
      endcase
   end
endmodule

// [rtl/uefc_top.sv]
// Enhanced feature control of one serial channel: registers, gating and control outputs.
`timescale 1ns/1ps
module uefc_top
   import uefc_pkg::*;
(
   // Clock and reset.
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   // Register port.
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Receive FIFO level and thresholds from the FIFO logic.
   input  wire logic [8:0] rx_level,
   input  wire logic [8:0] rx_trigger,
   input  wire logic [8:0] rx_next_up,
   input  wire logic [8:0] rx_next_down,
   // Transmit path status.
   input  wire logic       thr_empty,
   input  wire logic       tsr_empty,
   input  wire logic       tx_load,
   input  wire logic       tx_fifo_empty,
   input  wire logic       flow_char_req,
   input  wire logic       flow_char_pending,
   // Receive path events.
   input  wire logic       rx_char_valid,
   input  wire logic [7:0] rx_char,
   input  wire logic       rx_busy,
   input  wire logic       rx_is_flow_char,
   // Modem inputs, active low pins.
   input  wire logic       cts_n,
   input  wire logic       dsr_n,
   input  wire logic       irda_rx_in,
   // Control outputs.
   output logic            tx_data_enable,
   output logic            tx_flow_enable,
   output logic            rx_store,
   output logic            rx_flow_act,
   output logic            rx_shift_enable,
   output logic            tx_irq,
   output logic            rx_trig_irq,
   output logic            special_irq,
   output logic            xoff_irq,
   output logic            rts_n,
   output logic            dtr_n,
   output logic            irda_rx_norm,
   output logic      [1:0] trigger_table,
   output logic      [3:0] turn_delay,
   output logic      [3:0] flow_select
);
   // Plain registers.
   logic [7:0] scratch_pad;          // General purpose byte.
   logic [7:0] feature_control;      // Table, RS-485, polarity, hysteresis.
   logic [7:0] enhanced_feature;     // Flow control and enable bits.
   logic [7:0] pause_char_two;       // Second pause character, special match.
   // Gated registers.
   logic [7:0] modem_status_aux_reg; // Write-only auxiliary bits.
   logic [7:0] modem_control_reg;    // Modem control.
   logic [7:0] interrupt_enable_reg; // Interrupt enables.
   logic [7:0] fifo_control_reg;     // FIFO control.
   // Internal state.
   logic       auto_flow_hi;         // Hardware flow output deasserted.
   logic       dir_tx;               // RS-485 direction is transmit.
   logic       tx_pend_latch;        // One pending flow char allowed.
   logic       rx_gate;              // Receiver accepting characters.
   logic [5:0] hyst_chars;           // Hysteresis in characters.
   logic       enh_open;             // Gate for enhanced writes.
   logic       wr_sc;
   logic       wr_fc;
   logic       wr_ef;
   logic       wr_pc;
   logic       rts_sel;
   logic       next_flow_hi;
   logic [9:0] up_lvl;
   logic [9:0] dn_lvl;
   logic       spc_match;

   assign enh_open = enhanced_feature[UEFC_EF_ENH_EN];
   assign wr_sc    = reg_wr && (reg_addr == UEFC_OFF_SCRATCH);
   assign wr_fc    = reg_wr && (reg_addr == UEFC_OFF_FEATURE);
   assign wr_ef    = reg_wr && (reg_addr == UEFC_OFF_ENHANCED);
   assign wr_pc    = reg_wr && (reg_addr == UEFC_OFF_FLOW_CHR);
   assign rts_sel  = ~modem_control_reg[UEFC_MC_SEL];

   // Gated enhanced registers; the whole auxiliary byte is gated.
   uefc_gated_reg #(.GATED(UEFC_MASK_ALL)) u_aux (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .wr       (reg_wr && (reg_addr == UEFC_OFF_MODEM_AUX)),
      .gate_open(enh_open),
      .wdata    (reg_wdata),
      .q        (modem_status_aux_reg)
   );
   uefc_gated_reg #(.GATED(UEFC_MASK_753)) u_mcr (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .wr       (reg_wr && (reg_addr == UEFC_OFF_MODEM_CTL)),
      .gate_open(enh_open),
      .wdata    (reg_wdata),
      .q        (modem_control_reg)
   );
   uefc_gated_reg #(.GATED(UEFC_MASK_753)) u_ier (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .wr       (reg_wr && (reg_addr == UEFC_OFF_IRQ_EN)),
      .gate_open(enh_open),
      .wdata    (reg_wdata),
      .q        (interrupt_enable_reg)
   );
   uefc_gated_reg #(.GATED(UEFC_MASK_54)) u_fcr (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .wr       (reg_wr && (reg_addr == UEFC_OFF_FIFO_CTL)),
      .gate_open(enh_open),
      .wdata    (reg_wdata),
      .q        (fifo_control_reg)
   );

   // Scratch byte keeps its value until written; only reset restores all ones.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         scratch_pad <= UEFC_RST_SCRATCH;
      end else if (wr_sc) begin
         scratch_pad <= reg_wdata;
      end
   end

   // Feature control register.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         feature_control <= UEFC_RST_ZERO;
      end else if (wr_fc) begin
         feature_control <= reg_wdata;
      end
   end

   // Enhanced feature register.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         enhanced_feature <= UEFC_RST_ZERO;
      end else if (wr_ef) begin
         enhanced_feature <= reg_wdata;
      end
   end

   // Second pause character, used for special character matching.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pause_char_two <= UEFC_RST_ZERO;
      end else if (wr_pc) begin
         pause_char_two <= reg_wdata;
      end
   end

   // Read data one cycle after the strobe; unmapped offsets read zero.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= UEFC_RST_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            UEFC_OFF_SCRATCH:  reg_rdata <= scratch_pad;
            UEFC_OFF_FEATURE:  reg_rdata <= feature_control;
            UEFC_OFF_ENHANCED: reg_rdata <= enhanced_feature;
            UEFC_OFF_MODEM_CTL: reg_rdata <= modem_control_reg;
            UEFC_OFF_IRQ_EN:   reg_rdata <= interrupt_enable_reg;
            UEFC_OFF_FIFO_CTL: reg_rdata <= fifo_control_reg;
            UEFC_OFF_STATUS:   reg_rdata <= {4'h0, dir_tx, auto_flow_hi, rx_gate,
                                             tx_pend_latch};
            default:           reg_rdata <= UEFC_RST_ZERO;
         endcase
      end else begin
         reg_rdata <= UEFC_RST_ZERO;
      end
   end

   // Hysteresis lookup.
   uefc_hyst_lut u_hyst (
      .code (feature_control[3:0]),
      .chars(hyst_chars)
   );

   // Thresholds: table D with a nonzero hysteresis code uses hysteresis, all other cases use next trigger levels.
   always_comb begin
      if (feature_control[UEFC_FC_TABLE_HI:UEFC_FC_TABLE_LO] == UEFC_TABLE_D
          && hyst_chars != 6'h00) begin
         up_lvl = {1'b0, rx_trigger} + {4'h0, hyst_chars};
         dn_lvl = ({1'b0, rx_trigger} > {4'h0, hyst_chars}) ?
                  ({1'b0, rx_trigger} - {4'h0, hyst_chars}) : 10'h000;
      end else begin
         up_lvl = {1'b0, rx_next_up};
         dn_lvl = {1'b0, rx_next_down};
      end
   end

   // Hardware flow output level with hysteresis between the two thresholds.
   always_comb begin
      next_flow_hi = auto_flow_hi;
      if ({1'b0, rx_level} >= up_lvl) begin
         next_flow_hi = 1'b1;
      end else if ({1'b0, rx_level} < dn_lvl) begin
         next_flow_hi = 1'b0;
      end
   end

   // Automatic flow state is only tracked while the feature is enabled.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         auto_flow_hi <= 1'b0;
      end else if (enhanced_feature[UEFC_EF_AUTO_RTS]) begin
         auto_flow_hi <= next_flow_hi;
      end else begin
         auto_flow_hi <= 1'b0;
      end
   end

   // RS-485 direction: high on load, low once the shifter has drained.
   // A flow character sent with an empty FIFO does not turn the line around.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_tx <= 1'b0;
      end else if (tx_load) begin
         dir_tx <= 1'b1;
      end else if (flow_char_req && tx_fifo_empty) begin
         dir_tx <= dir_tx;
      end else if (tsr_empty && thr_empty) begin
         dir_tx <= 1'b0;
      end
   end

   // Output pins; modem control bits 0 and 1 give the general purpose level.
   always_comb begin
      rts_n = ~modem_control_reg[1];
      dtr_n = ~modem_control_reg[0];
      if (feature_control[UEFC_FC_RS485]) begin
         if (rts_sel) begin
            rts_n = dir_tx;
         end else begin
            dtr_n = dir_tx;
         end
      end else if (enhanced_feature[UEFC_EF_AUTO_RTS]) begin
         // Automatic control acts only once software has asserted the output.
         if (rts_sel && modem_control_reg[1]) begin
            rts_n = auto_flow_hi;
         end else if (!rts_sel && modem_control_reg[0]) begin
            dtr_n = auto_flow_hi;
         end
      end
   end

   // A flow character pending at disable time may still leave once.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_pend_latch <= 1'b0;
      end else if (!modem_status_aux_reg[UEFC_MA_TX_DIS]) begin
         tx_pend_latch <= flow_char_pending;
      end else if (!flow_char_pending) begin
         tx_pend_latch <= 1'b0;
      end
   end

   // Transmit enables.
   always_comb begin
      tx_data_enable = ~modem_status_aux_reg[UEFC_MA_TX_DIS];
      if (enhanced_feature[UEFC_EF_AUTO_CTS]) begin
         if (rts_sel ? cts_n : dsr_n) begin
            tx_data_enable = 1'b0;
         end
      end
      if (!modem_status_aux_reg[UEFC_MA_TX_DIS]) begin
         tx_flow_enable = 1'b1;
      end else if (modem_status_aux_reg[UEFC_MA_TX_MODE]) begin
         tx_flow_enable = 1'b1;
      end else begin
         tx_flow_enable = tx_pend_latch;
      end
   end

   // Receiver gate drops only between characters.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_gate <= 1'b1;
      end else if (!modem_status_aux_reg[UEFC_MA_RX_DIS]) begin
         rx_gate <= 1'b1;
      end else if (!rx_busy) begin
         rx_gate <= 1'b0;
      end
   end

   // Special character match.
   assign spc_match = enhanced_feature[UEFC_EF_SPECIAL] && (rx_char == pause_char_two);
   assign rx_shift_enable = rx_gate || rx_busy;

   // Receive routing.
   always_comb begin
      rx_store    = 1'b0;
      rx_flow_act = 1'b0;
      special_irq = 1'b0;
      xoff_irq    = 1'b0;
      if (rx_char_valid) begin
         if (rx_gate) begin
            rx_flow_act = rx_is_flow_char;
            rx_store = !(rx_is_flow_char && !spc_match);
            special_irq = spc_match;
            if (spc_match && enhanced_feature[1:0] == 2'h1) begin
               rx_store = 1'b0;
               xoff_irq = 1'b1;
            end
         end else if (modem_status_aux_reg[UEFC_MA_RX_MODE]) begin
            rx_flow_act = rx_is_flow_char;
         end else begin
            rx_flow_act = 1'b0;
         end
      end
   end

   // Interrupt sources and pass-through fields.
   assign tx_irq = feature_control[UEFC_FC_RS485] ? tsr_empty : thr_empty;
   assign rx_trig_irq = enhanced_feature[UEFC_EF_AUTO_RTS] && (rx_level >= rx_trigger);
   assign irda_rx_norm = feature_control[UEFC_FC_IRPOL] ? ~irda_rx_in : irda_rx_in;
   assign trigger_table = feature_control[UEFC_FC_TABLE_HI:UEFC_FC_TABLE_LO];
   assign turn_delay = modem_status_aux_reg[7:4];
   assign flow_select = enhanced_feature[3:0];

   // Checks.
   scratch_reset_a: assert property (@(posedge core_clk) $rose(arst_n) |->
      scratch_pad == 8'hFF) else $error("scratch not all ones after reset");
   tx_irq_src_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      feature_control[5] && !tsr_empty |-> !tx_irq) else $error("tx irq early");
   rs485_prec_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      feature_control[5] && rts_sel |-> rts_n == dir_tx) else $error("rs485 lost");
   dir_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      tx_load |=> dir_tx) else $error("direction not high after load");
   tx_dis_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      modem_status_aux_reg[3] |-> !tx_data_enable) else $error("data sent while off");
   tx_mode1_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      modem_status_aux_reg[3] && modem_status_aux_reg[1] |-> tx_flow_enable)
      else $error("flow char blocked in mode 1");
   rx_mode0_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !rx_gate && !modem_status_aux_reg[0] |-> !rx_flow_act && !rx_store)
      else $error("rx active while off");
   rx_mode1_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !rx_gate && rx_char_valid |-> !rx_store) else $error("data kept while off");
   irda_pol_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      irda_rx_norm == (irda_rx_in ^ feature_control[4])) else $error("ir polarity");
   enh_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !enh_open |=> $stable(modem_status_aux_reg)) else $error("gated bits changed");
   cts_stop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      enhanced_feature[7] && rts_sel && cts_n |-> !tx_data_enable)
      else $error("cts did not stop tx");
endmodule

// [tb/uefc_modem_model.sv]
// Behavioural modem that stands on the serial side of the channel.
`timescale 1ns/1ps
module uefc_modem_model #(
   parameter int LAG = 1
) (
   // Clock.
   input  wire logic core_clk,
   // Wishes of the bench.
   input  wire logic full,
   input  wire logic ir_bit,
   // Pins toward the channel, active low.
   output logic      cts_n,
   output logic      dsr_n,
   output logic      irda_rx_in
);
   logic [7:0] pipe = 8'h00; // History of the buffer-full wish.
   // A modem is slow to stop the far end, so the wish shows after LAG cycles.
   always @(posedge core_clk) begin
      pipe <= {pipe[6:0], full};
   end
   // DSR reports the opposite of CTS, so a wrong pin selection is seen.
   assign cts_n = pipe[LAG-1];
   assign dsr_n = ~pipe[LAG-1];
   assign irda_rx_in = ir_bit; // Encoded infrared data as sent.
endmodule

// [tb/uefc_top_test.sv]
// Self-checking bench of the enhanced feature control block.
`timescale 1ns/1ps
module uefc_top_test;
   import uefc_pkg::*;
   logic       core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0, turn_delay, flow_select;
   logic [7:0] reg_wdata = 8'h00, rx_char = 8'h00, reg_rdata, d, v;
   logic [8:0] rx_level = 9'h000, rx_trigger = 9'h038, rx_next_up = 9'h03C;
   logic [8:0] rx_next_down = 9'h010;
   logic       thr_empty = 1'b1, tsr_empty = 1'b1, tx_load = 1'b0, tx_fifo_empty = 1'b1;
   logic       flow_char_req = 1'b0, flow_char_pending = 1'b0, rx_char_valid = 1'b0;
   logic       rx_busy = 1'b0, rx_is_flow_char = 1'b0, full = 1'b0, ir_bit = 1'b0;
   logic       cts_n, dsr_n, irda_rx_in, tx_data_enable, tx_flow_enable, rx_store;
   logic       rx_flow_act, rx_shift_enable, tx_irq, rx_trig_irq, special_irq, xoff_irq;
   logic       rts_n, dtr_n, irda_rx_norm, s, fa, sp, xo;
   logic [1:0] trigger_table;
   logic [15:0] lfsr = 16'hA9E4; // Seed 43492.
   int         err_count = 0, n_tests = 0;
   // Free running 200 MHz clock.
   always #2.5 core_clk = ~core_clk;
   uefc_top DUT (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .rx_level, .rx_trigger, .rx_next_up, .rx_next_down, .thr_empty, .tsr_empty, .tx_load,
      .tx_fifo_empty, .flow_char_req, .flow_char_pending, .rx_char_valid, .rx_char,
      .rx_busy, .rx_is_flow_char, .cts_n, .dsr_n, .irda_rx_in, .tx_data_enable,
      .tx_flow_enable, .rx_store, .rx_flow_act, .rx_shift_enable, .tx_irq, .rx_trig_irq,
      .special_irq, .xoff_irq, .rts_n, .dtr_n, .irda_rx_norm, .trigger_table, .turn_delay,
      .flow_select);
   // Slow modem: stopping shows a few cycles late.
   uefc_modem_model #(.LAG(3)) modem (.core_clk, .full, .ir_bit, .cts_n, .dsr_n, .irda_rx_in);
   // Next random value.
   function automatic logic [15:0] next_rand(input logic [15:0] r);
      return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
   endfunction
   // Table D raise level; code 0 keeps the next trigger level.
   function automatic logic [8:0] hyst_up(input logic [3:0] c);
      logic [8:0] t[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
      return (c == 4'h0) ? rx_next_up : rx_trigger + t[c];
   endfunction
   // One counted compare.
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Register write of one strobe cycle.
   task automatic wr(input logic [3:0] a, input logic [7:0] w);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Register read; data are taken in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, output logic [7:0] q);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   // Let one edge pass and the outputs settle.
   task automatic step;
      @(posedge core_clk);
      #1;
   endtask
   // New receive level at an edge, then one settled edge.
   task automatic set_lvl(input logic [8:0] l);
      @(posedge core_clk);
      rx_level <= l;
      step;
   endtask
   // One received character; flags are sampled while valid stands.
   task automatic rx_in(input logic [7:0] c, input logic f);
      @(posedge core_clk);
      rx_char_valid <= 1'b1;
      rx_char <= c;
      rx_is_flow_char <= f;
      #1 {s, fa, sp, xo} = {rx_store, rx_flow_act, special_irq, xoff_irq};
      @(posedge core_clk);
      rx_char_valid <= 1'b0;
   endtask
   // Bounded wait for the pin, then a compare.
   task automatic wait_rts(input logic e);
      for (int i = 0; i < 20 && rts_n !== e; i++) step;
      check("rts_n", {7'h0, rts_n}, {7'h0, e});
   endtask
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // The run should take a few hundred cycles; this cuts a hang short.
   initial begin
      #200000;
      err_count++;
      give_verdict;
   end
   initial begin
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      rd(UEFC_OFF_SCRATCH, d); check("scratch", d, UEFC_RST_SCRATCH);
      rd(UEFC_OFF_FEATURE, d); check("feature", d, UEFC_RST_ZERO);
      rd(UEFC_OFF_ENHANCED, d); check("enhanced", d, UEFC_RST_ZERO);
      rd(4'hF, d); check("unmapped", d, 8'h00);
      // Gate closed: upper modem bits and the auxiliary byte are refused.
      wr(UEFC_OFF_MODEM_CTL, 8'hE4); rd(UEFC_OFF_MODEM_CTL, d); check("mcr", d, 8'h04);
      wr(UEFC_OFF_MODEM_AUX, 8'h08); step; check("txen", tx_data_enable, 8'h01);
      wr(UEFC_OFF_ENHANCED, 8'h10);
      wr(UEFC_OFF_MODEM_CTL, 8'hE0); rd(UEFC_OFF_MODEM_CTL, d); check("mcr", d, 8'hE0);
      wr(UEFC_OFF_ENHANCED, 8'h00);
      wr(UEFC_OFF_MODEM_CTL, 8'h00); rd(UEFC_OFF_MODEM_CTL, d); check("mcr", d, 8'hE0);
      wr(UEFC_OFF_ENHANCED, 8'h10);
      wr(UEFC_OFF_MODEM_CTL, 8'h00);
      rd(UEFC_OFF_MODEM_AUX, d); check("aux read", d, 8'h00);
      // Random scratch contents.
      repeat (8) begin
         lfsr = next_rand(lfsr);
         wr(UEFC_OFF_SCRATCH, lfsr[7:0]); rd(UEFC_OFF_SCRATCH, d); check("scratch", d, lfsr[7:0]);
      end
      for (int i = 0; i < 4; i++) begin
         wr(UEFC_OFF_FEATURE, {i[1:0], 6'h00}); step; check("table", trigger_table, i[7:0]);
      end
      for (int i = 0; i < 16; i++) begin
         wr(UEFC_OFF_ENHANCED, 8'h10);
         wr(UEFC_OFF_ENHANCED, 8'h10 | i[7:0]); step; check("flow", flow_select, i[7:0]);
      end
      wr(UEFC_OFF_ENHANCED, 8'h10);
      // Transmitter disabled in both sub-modes.
      @(posedge core_clk);
      flow_char_pending <= 1'b1;
      wr(UEFC_OFF_MODEM_AUX, 8'h08); step; check("txen", tx_data_enable, 8'h00);
      check("pend", tx_flow_enable, 8'h01);
      @(posedge core_clk);
      flow_char_pending <= 1'b0;
      @(posedge core_clk);
      flow_char_pending <= 1'b1;
      step; check("flow", tx_flow_enable, 8'h00);
      wr(UEFC_OFF_MODEM_AUX, 8'h5A); step; check("flow", tx_flow_enable, 8'h01);
      check("txen", tx_data_enable, 8'h00);
      check("delay", turn_delay, 8'h05);
      // Receiver disabled in both sub-modes.
      wr(UEFC_OFF_MODEM_AUX, 8'h04); rx_in(8'h13, 1'b1); check("rx", {s, fa}, 8'h00);
      wr(UEFC_OFF_MODEM_AUX, 8'h05); rx_in(8'h13, 1'b1); check("rx", {s, fa}, 8'h01);
      @(posedge core_clk);
      rx_busy <= 1'b1;
      #1 check("shift", rx_shift_enable, 8'h01);
      @(posedge core_clk);
      rx_busy <= 1'b0;
      #1 check("shift", rx_shift_enable, 8'h00);
      wr(UEFC_OFF_MODEM_AUX, 8'h00); rx_in(8'h41, 1'b0); check("store", s, 8'h01);
      // Special character against the second pause character.
      lfsr = next_rand(lfsr);
      v = lfsr[7:0];
      wr(UEFC_OFF_FLOW_CHR, v);
      wr(UEFC_OFF_ENHANCED, 8'h30); rx_in(v, 1'b0); check("spec", {s, sp}, 8'h03);
      rx_in(~v, 1'b0); check("spec", sp, 8'h00);
      wr(UEFC_OFF_ENHANCED, 8'h31); rx_in(v, 1'b1); check("pair2", {s, sp, xo}, 8'h03);
      wr(UEFC_OFF_ENHANCED, 8'h30);
      wr(UEFC_OFF_ENHANCED, 8'h32); rx_in(v, 1'b0); check("pair1", {s, sp}, 8'h03);
      // Infrared polarity.
      for (int i = 0; i < 4; i++) begin
         wr(UEFC_OFF_FEATURE, {3'h0, i[1], 4'h0});
         @(posedge core_clk);
         ir_bit <= i[0];
         repeat (2) step;
         check("irda", irda_rx_norm, {7'h0, i[0] ^ i[1]});
      end
      // Transmit interrupt source, then half duplex direction.
      @(posedge core_clk);
      tsr_empty <= 1'b0;
      wr(UEFC_OFF_FEATURE, 8'h00); step; check("txirq", tx_irq, 8'h01);
      wr(UEFC_OFF_FEATURE, 8'h20); step; check("txirq", tx_irq, 8'h00);
      @(posedge core_clk);
      {thr_empty, tx_fifo_empty, tx_load} <= 3'b001;
      @(posedge core_clk);
      tx_load <= 1'b0;
      wait_rts(1'b1);
      @(posedge core_clk);
      {thr_empty, tsr_empty, tx_fifo_empty} <= 3'b111;
      wait_rts(1'b0);
      @(posedge core_clk);
      flow_char_req <= 1'b1;
      @(posedge core_clk);
      flow_char_req <= 1'b0;
      repeat (4) step;
      check("dir", rts_n, 8'h00);
      // Level flow control; RS-485 direction wins over it.
      wr(UEFC_OFF_ENHANCED, 8'h50);
      wr(UEFC_OFF_MODEM_CTL, 8'h02);
      set_lvl(9'd70);
      repeat (3) step;
      check("dir", rts_n, 8'h00);
      wr(UEFC_OFF_FEATURE, 8'h00); wait_rts(1'b1);
      check("trig", rx_trig_irq, 8'h01);
      set_lvl(9'd30);
      repeat (3) step;
      check("hold", rts_n, 8'h01);
      set_lvl(9'd10);
      wait_rts(1'b0);
      for (int i = 0; i < 16; i++) begin
         wr(UEFC_OFF_FEATURE, {4'hC, i[3:0]});
         set_lvl(hyst_up(i[3:0]) - 9'd1); check("hyst", rts_n, 8'h00);
         set_lvl(hyst_up(i[3:0])); check("hyst", rts_n, 8'h01);
         set_lvl(9'd0);
      end
      wr(UEFC_OFF_ENHANCED, 8'h10);
      wr(UEFC_OFF_MODEM_CTL, 8'h01); step; check("gp", {rts_n, dtr_n}, 8'h02);
      // Automatic stop on the modem pins.
      wr(UEFC_OFF_ENHANCED, 8'h90);
      @(posedge core_clk);
      full <= 1'b1;
      repeat (5) step;
      check("cts", tx_data_enable, 8'h00);
      wr(UEFC_OFF_MODEM_CTL, 8'h04); step; check("dsr", tx_data_enable, 8'h01);
      give_verdict;
   end
endmodule
